/* File: src/port_upper_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the upper port mux
`ifndef PORT_UPPER_CFG_SVH
`define PORT_UPPER_CFG_SVH

// APB byte offsets, one aligned word each
`define PIN_LEVEL_OFF 12'h000
`define OUTPUT_LATCH_OFF 12'h004
`define DIRECTION_CTRL_OFF 12'h008

// Reset values: all pins inputs, latch cleared
`define OUTPUT_LATCH_RST 8'h00
`define DIRECTION_CTRL_RST 8'hff

// Pin positions handled by the mux
`define BIT_FIVE 5
`define BIT_SIX 6
`define BIT_SEVEN 7
`define UPPER_LSB 5

// Register width and pipeline depth of the pin outputs
`define PORT_WIDTH 8
`define OUT_PIPE_CYCLES 1

`endif

/* File: src/port_upper_pkg.sv */
// Types shared by the upper port mux files
package port_upper_pkg;

    // Which source owns a pin
    typedef enum logic [3:0] {
        OWN_PORT = 4'b0001,
        OWN_PSP = 4'b0010,
        OWN_SER = 4'b0100,
        OWN_EXT = 4'b1000
    } owner_t;

    // Mode of the second serial module
    typedef enum logic [2:0] {
        SER_OFF = 3'b001,
        SER_SPI = 3'b010,
        SER_I2C = 3'b100
    } ser_mode_t;

    // Input buffer type applied to a pin
    typedef enum logic [2:0] {
        BUF_ST = 3'b001,
        BUF_TTL = 3'b010,
        BUF_I2C = 3'b100
    } buf_t;

endpackage : port_upper_pkg

/* File: src/pin_owner_arbiter.sv */
// Fixed-priority source selection for one port pin
`timescale 1ns/100ps
module pin_owner_arbiter #(
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic ext_en,
    input wire logic ext_read,
    input wire logic ext_out,
    input wire logic ser_req,
    input wire logic ser_out,
    input wire logic ser_oe,
    input wire logic psp_en,
    input wire logic psp_rd,
    input wire logic lat,
    input wire logic dir,
    output port_upper_pkg::owner_t owner,
    output logic pin_o,
    output logic pin_oe
);
    import port_upper_pkg::*;

    // Memory bus, then serial, then slave port, then plain port
    always_comb begin
        owner = OWN_PORT;
        pin_o = lat;
        pin_oe = ~dir;
        if (HAS_EXT && ext_en) begin
            owner = OWN_EXT;
            pin_o = ext_out;
            pin_oe = ~ext_read; // Direction bit ignored
        end else if (ser_req) begin
            owner = OWN_SER;
            pin_o = ser_out;
            pin_oe = ser_oe;
        end else if (psp_en) begin
            owner = OWN_PSP;
            pin_o = lat;
            pin_oe = psp_rd; // Host write leaves pin as input
        end
    end

endmodule : pin_owner_arbiter

/* File: src/pin_input_capture.sv */
// Samples the port pins and latches bus and slave-port write data from them
`timescale 1ns/100ps
module pin_input_capture #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic ext_sample,
    input wire logic psp_write,
    output logic [WIDTH-1:0] pins_q,
    output logic [WIDTH-1:0] ext_data_q,
    output logic [WIDTH-1:0] psp_wdata_q
);

    // Pin levels as seen by the pin level register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pins_q <= '0;
        end else if (ce) begin
            pins_q <= pin_i;
        end
    end

    // Bus read data, only during read phases
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ext_data_q <= '0;
        end else if (ce && ext_sample) begin
            ext_data_q <= pin_i;
        end
    end

    // Host write data into the slave port
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            psp_wdata_q <= '0;
        end else if (ce && psp_write) begin
            psp_wdata_q <= pin_i;
        end
    end

endmodule : pin_input_capture

/* File: src/port_upper_pin_function_mux.sv */
// Upper port pin-function mux with its pin level, latch and direction registers
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "port_upper_cfg.svh"
module port_upper_pin_function_mux #(
    parameter bit LARGE_PACKAGE = 1'b1,
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe,
    output port_upper_pkg::buf_t buf_sel_five,
    output port_upper_pkg::buf_t buf_sel_six,
    output port_upper_pkg::buf_t buf_sel_seven,
    output logic smb_levels_sel,
    output logic [4:0] low_latch_o,
    output logic [4:0] low_dir_o,
    input wire logic ext_bus_en,
    input wire logic ext_bus_read,
    input wire logic [2:0] ext_bus_out,
    output logic [2:0] ext_bus_data_in,
    input wire logic slave_port_en,
    input wire logic rd_strobe_n_pin,
    input wire logic wr_strobe_n_pin,
    input wire logic cs_n_pin,
    output logic slave_port_read,
    output logic slave_port_write,
    output logic [2:0] slave_port_wdata,
    input wire port_upper_pkg::ser_mode_t ser_mode,
    input wire logic ser_smb_levels,
    input wire logic serial_clock_out,
    input wire logic two_wire_data_low,
    input wire logic two_wire_clock_low,
    output logic serial_data_in,
    output logic serial_clock_in,
    output logic slave_select_in,
    output logic two_wire_data_in,
    output logic two_wire_clock_in
);
    import port_upper_pkg::*;

    logic [WIDTH-1:0] output_latch_register_q;
    logic [WIDTH-1:0] direction_control_register_q;
    logic [WIDTH-1:0] pins_q;
    logic [WIDTH-1:0] ext_data_q;
    logic [WIDTH-1:0] psp_wdata_q;
    logic [2:0] ser_req;
    logic [2:0] ser_out;
    logic [2:0] ser_oe;
    logic [2:0] mux_o;
    logic [2:0] mux_oe;
    owner_t owner [3];
    logic ext_active;
    logic wr_en;
    logic addr_hit;
    logic spi_mode;
    logic i2c_mode;

    // Word-aligned decode of the three registers
    function automatic logic decode_hit(input logic [11:0] addr);
        decode_hit = (addr == `PIN_LEVEL_OFF) || (addr == `OUTPUT_LATCH_OFF)
                     || (addr == `DIRECTION_CTRL_OFF);
    endfunction : decode_hit

    // Buffer type while no peripheral overrides the pin
    function automatic buf_t port_buf(input logic ext_or_psp);
        port_buf = ext_or_psp ? BUF_TTL : BUF_ST;
    endfunction : port_buf

    // No wait states; unmapped words answer with an error
    assign addr_hit = decode_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = ce && psel && penable && pwrite && addr_hit;
    assign ext_active = LARGE_PACKAGE && ext_bus_en;
    assign spi_mode = (ser_mode == SER_SPI);
    assign i2c_mode = (ser_mode == SER_I2C);

    // Writes to the pin level word land in the latch, as on a real port
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            output_latch_register_q <= `OUTPUT_LATCH_RST;
        end else if (wr_en && (paddr == `PIN_LEVEL_OFF || paddr == `OUTPUT_LATCH_OFF)) begin
            output_latch_register_q <= pwdata[WIDTH-1:0];
        end
    end

    // Direction bits, one per pin, 1 means input
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            direction_control_register_q <= `DIRECTION_CTRL_RST;
        end else if (wr_en && paddr == `DIRECTION_CTRL_OFF) begin
            direction_control_register_q <= pwdata[WIDTH-1:0];
        end
    end

    // Read data registered for the next access phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            unique case (paddr)
                `PIN_LEVEL_OFF: prdata <= {24'h00_0000, pins_q};
                `OUTPUT_LATCH_OFF: prdata <= {24'h00_0000, output_latch_register_q};
                `DIRECTION_CTRL_OFF: prdata <= {24'h00_0000, direction_control_register_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Slave port strobes come from the neighbouring port's pins
    assign slave_port_read = slave_port_en && !cs_n_pin && !rd_strobe_n_pin;
    assign slave_port_write = slave_port_en && !cs_n_pin && !wr_strobe_n_pin;

    pin_input_capture #(
        .WIDTH(WIDTH)
    ) u_capture (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .pin_i(pin_i),
        .ext_sample(ext_active && ext_bus_read),
        .psp_write(slave_port_write),
        .pins_q(pins_q),
        .ext_data_q(ext_data_q),
        .psp_wdata_q(psp_wdata_q)
    );

    // Captured data handed to the bus and slave port, upper bits only
    assign ext_bus_data_in = ext_data_q[`BIT_SEVEN:`UPPER_LSB];
    assign slave_port_wdata = psp_wdata_q[`BIT_SEVEN:`UPPER_LSB];
    assign low_latch_o = output_latch_register_q[4:0];
    assign low_dir_o = direction_control_register_q[4:0];

    // Serial claims: two-wire pins are open drain, driving only low
    always_comb begin
        ser_req = 3'b000;
        ser_out = 3'b000;
        ser_oe = 3'b000;
        if (i2c_mode) begin
            ser_req[0] = 1'b1;
            ser_oe[0] = two_wire_data_low && direction_control_register_q[`BIT_FIVE];
            ser_req[1] = 1'b1;
            ser_oe[1] = two_wire_clock_low;
        end else if (spi_mode && !direction_control_register_q[`BIT_SIX]) begin
            ser_req[1] = 1'b1; // Master clock out
            ser_out[1] = serial_clock_out;
            ser_oe[1] = 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            pin_owner_arbiter #(
                .HAS_EXT(LARGE_PACKAGE)
            ) u_arb (
                .ext_en(ext_bus_en),
                .ext_read(ext_bus_read),
                .ext_out(ext_bus_out[gi]),
                .ser_req(ser_req[gi]),
                .ser_out(ser_out[gi]),
                .ser_oe(ser_oe[gi]),
                .psp_en(slave_port_en),
                .psp_rd(slave_port_read),
                .lat(output_latch_register_q[`UPPER_LSB+gi]),
                .dir(direction_control_register_q[`UPPER_LSB+gi]),
                .owner(owner[gi]),
                .pin_o(mux_o[gi]),
                .pin_oe(mux_oe[gi])
            );
        end
    endgenerate

    // Pin drive registered so the pad sees clean edges
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_o <= 3'b000;
            pin_oe <= 3'b000;
        end else if (ce) begin
            pin_o <= mux_o;
            pin_oe <= mux_oe;
        end
    end

    // Serial inputs; slave select idles high unless SPI mode has bit seven as an input
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serial_data_in <= 1'b0;
            serial_clock_in <= 1'b0;
            slave_select_in <= 1'b1;
            two_wire_data_in <= 1'b1;
            two_wire_clock_in <= 1'b1;
        end else if (ce) begin
            serial_data_in <= spi_mode && direction_control_register_q[`BIT_FIVE]
                              && pin_i[`BIT_FIVE];
            serial_clock_in <= spi_mode && direction_control_register_q[`BIT_SIX]
                               && pin_i[`BIT_SIX];
            slave_select_in <= !(spi_mode && direction_control_register_q[`BIT_SEVEN])
                               || pin_i[`BIT_SEVEN];
            two_wire_data_in <= !i2c_mode || pin_i[`BIT_FIVE];
            two_wire_clock_in <= !i2c_mode || pin_i[`BIT_SIX];
        end
    end

    // Input buffer per pin; bus uses TTL levels, slave port too except on two-wire pins five and six
    always_comb begin
        buf_sel_five = port_buf(ext_active || slave_port_en);
        buf_sel_six = port_buf(ext_active || slave_port_en);
        buf_sel_seven = port_buf(ext_active || slave_port_en);
        if (!ext_active && i2c_mode) begin
            buf_sel_five = BUF_I2C;
            buf_sel_six = BUF_I2C;
        end
        if (!ext_active && spi_mode && direction_control_register_q[`BIT_SEVEN]) begin
            buf_sel_seven = BUF_TTL;
        end
    end

    // SMBus thresholds follow the module only in two-wire mode
    assign smb_levels_sel = i2c_mode && ser_smb_levels;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_port_five;
        owner[0] == OWN_PORT && !direction_control_register_q[`BIT_FIVE] && ce;
    endsequence

    sequence s_ext_write;
        ext_active && !ext_bus_read && ce;
    endsequence

    sequence s_psp_read;
        !ext_active && !i2c_mode && slave_port_read && ce;
    endsequence

    chk_port_drive: assert property (
        s_port_five |=> pin_oe[0] && pin_o[0] == $past(output_latch_register_q[`BIT_FIVE]))
        else $error("port bit five not driven from latch");

    chk_port_input: assert property (
        owner[2] == OWN_PORT && direction_control_register_q[`BIT_SEVEN] && ce |=> !pin_oe[2])
        else $error("input pin is driven");

    chk_ext_priority: assert property (
        s_ext_write |=> pin_oe == 3'b111 && pin_o == $past(ext_bus_out))
        else $error("memory bus lost a pin");

    chk_ext_sample: assert property (
        ext_active && ext_bus_read && ce |=> ext_bus_data_in == $past(pin_i[7:5]))
        else $error("bus read data not sampled");

    chk_psp_read: assert property (
        s_psp_read |=> pin_oe[2] && pin_o[2] == $past(output_latch_register_q[`BIT_SEVEN]))
        else $error("slave port read not driven");

    chk_psp_write: assert property (
        slave_port_write && ce |=> slave_port_wdata == $past(pin_i[7:5]))
        else $error("slave port write data lost");

    chk_sda_dir: assert property (
        !ext_active && i2c_mode && !direction_control_register_q[`BIT_FIVE] && ce
        |=> !pin_oe[0])
        else $error("two-wire data driven with direction clear");

    chk_sck_master: assert property (
        !ext_active && spi_mode && !direction_control_register_q[`BIT_SIX] && ce
        |=> pin_oe[1] && pin_o[1] == $past(serial_clock_out))
        else $error("serial clock not driven as master");

    chk_buf_type: assert property (
        !ext_active && i2c_mode |-> buf_sel_five == BUF_I2C && buf_sel_six == BUF_I2C)
        else $error("two-wire buffer not selected");

    chk_ss_route: assert property (
        spi_mode && direction_control_register_q[`BIT_SEVEN] && ce
        |=> slave_select_in == $past(pin_i[`BIT_SEVEN]))
        else $error("slave select not routed");

    chk_latch_write: assert property (
        wr_en && paddr == `OUTPUT_LATCH_OFF |=> output_latch_register_q == $past(pwdata[7:0]))
        else $error("latch write lost");

    chk_small_pkg: assert property (
        !LARGE_PACKAGE && ext_bus_en && ce |=> $stable(ext_bus_data_in))
        else $error("memory bus present in small package");

    chk_ext_top: assert property (
        s_ext_write ##0 slave_port_read |=> pin_oe[2] && pin_o[2] == $past(ext_bus_out[2]))
        else $error("memory bus lost bit seven to the slave port");

    chk_ext_release: assert property (
        ext_active && ext_bus_read && ce |=> pin_oe == 3'b000)
        else $error("memory bus read left a pin driven");

    chk_sdi_route: assert property (
        spi_mode && direction_control_register_q[`BIT_FIVE] && ce
        |=> serial_data_in == $past(pin_i[`BIT_FIVE]))
        else $error("serial data input not routed");

    chk_psp_release: assert property (
        !ext_active && !i2c_mode && slave_port_write && !slave_port_read && ce
        |=> !pin_oe[2])
        else $error("slave port write left bit seven driven");

    chk_strobe_gate: assert property (
        !slave_port_en || cs_n_pin |-> !slave_port_read && !slave_port_write)
        else $error("slave port strobe without enable and select");

    chk_reg_freeze: assert property (
        !ce |=> $stable(output_latch_register_q) && $stable(direction_control_register_q))
        else $error("register changed with clock enable low");

    chk_ss_buffer: assert property (
        !ext_active && spi_mode && direction_control_register_q[`BIT_SEVEN]
        |-> buf_sel_seven == BUF_TTL)
        else $error("slave select buffer not selected");

endmodule : port_upper_pin_function_mux

/* File: tb/pin_peer_model.sv */
// Behavioural model of the peers wired to the three upper port pins
`timescale 1ns/100ps
module pin_peer_model (
    input wire logic mclk,
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] peer_en,
    input wire logic [2:0] peer_val,
    input wire logic pull_up,
    output logic [2:0] pin_lvl
);
    logic [2:0] idle_q = 3'h0;

    // Undriven lines wander every cycle, so a stale value never passes for data
    always @(posedge mclk) begin
        idle_q <= ~idle_q;
    end

    // Wire level: device drive wins, then the peer, then pull-up or wander
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i] === 1'b1) begin
                pin_lvl[i] = pin_o[i];
            end else if (peer_en[i]) begin
                pin_lvl[i] = peer_val[i];
            end else begin
                pin_lvl[i] = pull_up ? 1'b1 : idle_q[i];
            end
        end
    end
endmodule : pin_peer_model

/* File: tb/port_upper_pin_function_mux_tb.sv */
// Self-checking bench for the upper port pin-function mux
`timescale 1ns/100ps
`include "port_upper_cfg.svh"
module port_upper_pin_function_mux_tb;
    import port_upper_pkg::*;
    logic mclk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, smb_levels_sel, ext_bus_en = 0, ext_bus_read = 0;
    logic [2:0] pin_o, pin_oe, ext_bus_out = 3'h0, ext_bus_data_in, pin_lvl, wdata;
    logic [2:0] peer_en = 3'h0, peer_val = 3'h0;
    logic [4:0] low_pins = 5'h0, low_latch_o, low_dir_o;
    logic slave_port_en = 0, rd_n = 1, wr_n = 1, cs_n = 1, sp_rd, sp_wr, smb = 0;
    logic sco = 0, dlow = 0, clow = 0, sdi, sci, ssi, tdi, tci;
    ser_mode_t ser_mode = SER_OFF;
    buf_t b5, b6, b7;
    logic [32:0] exp_q[$];
    logic [7:0] v, lat;
    int err_count = 0, total_checks = 0;

    initial begin
        forever #10 mclk = ~mclk;
    end

    port_upper_pin_function_mux i_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_i({pin_lvl, low_pins}), .pin_o(pin_o),
        .pin_oe(pin_oe), .buf_sel_five(b5), .buf_sel_six(b6), .buf_sel_seven(b7),
        .smb_levels_sel(smb_levels_sel), .low_latch_o(low_latch_o), .low_dir_o(low_dir_o),
        .ext_bus_en(ext_bus_en), .ext_bus_read(ext_bus_read), .ext_bus_out(ext_bus_out),
        .ext_bus_data_in(ext_bus_data_in), .slave_port_en(slave_port_en),
        .rd_strobe_n_pin(rd_n), .wr_strobe_n_pin(wr_n), .cs_n_pin(cs_n),
        .slave_port_read(sp_rd), .slave_port_write(sp_wr), .slave_port_wdata(wdata),
        .ser_mode(ser_mode), .ser_smb_levels(smb), .serial_clock_out(sco),
        .two_wire_data_low(dlow), .two_wire_clock_low(clow), .serial_data_in(sdi),
        .serial_clock_in(sci), .slave_select_in(ssi), .two_wire_data_in(tdi),
        .two_wire_clock_in(tci));

    pin_peer_model i_peer (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .peer_en(peer_en),
        .peer_val(peer_val), .pull_up(ser_mode == SER_I2C), .pin_lvl(pin_lvl));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // One APB transfer; read expectations go to the queue before the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        if (!wr) begin
            exp_q.push_back(exp);
        end
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read results are taken at the edge where the master samples them
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            cmp({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // Outputs are registered, so give causes three edges to land
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    initial begin
        #2000000;
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hdfafad00));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        apb(0, `OUTPUT_LATCH_OFF, 8'h0, {1'b0, 24'h0, `OUTPUT_LATCH_RST});
        apb(0, `DIRECTION_CTRL_OFF, 8'h0, {1'b0, 24'h0, `DIRECTION_CTRL_RST});
        apb(0, 12'h00c, 8'h0, {1'b1, 32'h0});
        $display("Reset values done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            apb(1, `OUTPUT_LATCH_OFF, v, 33'h0);
            apb(1, `DIRECTION_CTRL_OFF, ~v, 33'h0);
            apb(0, `OUTPUT_LATCH_OFF, 8'h0, {25'h0, v});
            apb(0, `DIRECTION_CTRL_OFF, 8'h0, {25'h0, ~v});
            settle();
            cmp({28'h0, low_latch_o}, {28'h0, v[4:0]});
            cmp({28'h0, low_dir_o}, {28'h0, ~v[4:0]});
        end
        $display("Register access done");
        lat = 8'($urandom);
        apb(1, `PIN_LEVEL_OFF, lat, 33'h0);
        apb(0, `OUTPUT_LATCH_OFF, 8'h0, {25'h0, lat});
        apb(1, `DIRECTION_CTRL_OFF, 8'h00, 33'h0);
        settle();
        cmp(pin_oe, 3'b111);
        cmp(pin_o, lat[7:5]);
        cmp(b5, BUF_ST);
        cmp(b7, BUF_ST);
        apb(1, `DIRECTION_CTRL_OFF, 8'hff, 33'h0);
        peer_en <= 3'b111;
        peer_val <= 3'($urandom);
        low_pins <= 5'($urandom);
        settle();
        cmp(pin_oe, 3'b000);
        apb(0, `PIN_LEVEL_OFF, 8'h0, {25'h0, peer_val, low_pins});
        $display("Port mode done");
        // The slave port and the two-wire serial ask for the pins too; the memory bus must win
        slave_port_en <= 1'b1;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        ser_mode <= SER_I2C;
        dlow <= 1'b1;
        clow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ext_bus_en <= 1'b1;
            ext_bus_read <= 1'b0;
            ext_bus_out <= 3'($urandom);
            settle();
            cmp(pin_oe, 3'b111);
            cmp(pin_o, ext_bus_out);
            @(posedge mclk);
            ext_bus_read <= 1'b1;
            peer_val <= 3'($urandom);
            settle();
            cmp(pin_oe, 3'b000);
            cmp(ext_bus_data_in, peer_val);
            @(posedge mclk);
        end
        ext_bus_en <= 1'b0;
        smb <= 1'b1;
        settle();
        cmp(pin_oe, 3'b111);
        cmp(pin_o, {lat[7], 2'b00});
        cmp({b5, b6}, {BUF_I2C, BUF_I2C});
        cmp(smb_levels_sel, 1'b1);
        cmp({tdi, tci}, 2'b00);
        // Data line direction bit clear: the module may not drive bit five
        apb(1, `DIRECTION_CTRL_OFF, 8'hdf, 33'h0);
        settle();
        cmp(pin_oe, 3'b110);
        apb(1, `DIRECTION_CTRL_OFF, 8'hff, 33'h0);
        $display("Memory bus and two-wire done");
        ser_mode <= SER_OFF;
        dlow <= 1'b0;
        clow <= 1'b0;
        settle();
        cmp({sp_rd, pin_oe}, 4'b1111);
        cmp(pin_o, lat[7:5]);
        @(posedge mclk);
        rd_n <= 1'b1;
        wr_n <= 1'b0;
        peer_val <= 3'($urandom);
        settle();
        cmp({sp_wr, pin_oe}, 4'b1000);
        cmp(wdata, peer_val);
        @(posedge mclk);
        cs_n <= 1'b1;
        settle();
        cmp({sp_rd, sp_wr}, 2'b00);
        $display("Slave port done");
        @(posedge mclk);
        slave_port_en <= 1'b0;
        ser_mode <= SER_SPI;
        sco <= 1'($urandom);
        peer_val <= 3'($urandom);
        apb(1, `DIRECTION_CTRL_OFF, 8'hbf, 33'h0);
        settle();
        cmp({pin_oe[1], pin_o[1]}, {1'b1, sco});
        cmp(sdi, peer_val[0]);
        cmp(ssi, peer_val[2]);
        cmp(b7, BUF_TTL);
        cmp({tdi, tci}, 2'b11);
        apb(1, `DIRECTION_CTRL_OFF, 8'hff, 33'h0);
        settle();
        cmp(pin_oe, 3'b000);
        cmp(sci, peer_val[1]);
        $display("Serial done");
        // A write with the clock enable low must be lost
        @(posedge mclk);
        ser_mode <= SER_OFF;
        ce <= 1'b0;
        apb(1, `DIRECTION_CTRL_OFF, 8'h00, 33'h0);
        ce <= 1'b1;
        apb(0, `DIRECTION_CTRL_OFF, 8'h0, {1'b0, 24'h0, `DIRECTION_CTRL_RST});
        // Mid-run reset returns pins and serial inputs to their idle levels
        rstn <= 1'b0;
        settle();
        cmp({pin_oe, pin_o, ssi, tdi, tci, sdi, sci}, 11'h01c);
        @(posedge mclk);
        rstn <= 1'b1;
        apb(0, `OUTPUT_LATCH_OFF, 8'h0, {1'b0, 24'h0, `OUTPUT_LATCH_RST});
        $display("Enable and reset done");
        stop_test();
    end
endmodule : port_upper_pin_function_mux_tb
